// *** rtl/gfcfg_pkg.sv ***
// Package: register map, hardwired values and config access types for the graphics config header
package gfcfg_pkg;

  localparam logic [7:0]  GFCFG_OFS_CMD      = 8'h04;
  localparam logic [7:0]  GFCFG_OFS_STS      = 8'h06;
  localparam logic [7:0]  GFCFG_OFS_REV      = 8'h08;
  localparam logic [7:0]  GFCFG_OFS_PROGIF   = 8'h09;
  localparam logic [7:0]  GFCFG_OFS_SUBCLASS = 8'h0a;
  localparam logic [7:0]  GFCFG_OFS_BASECLS  = 8'h0b;
  localparam logic [7:0]  GFCFG_OFS_LINESZ   = 8'h0c;
  localparam logic [7:0]  GFCFG_OFS_LATTMR   = 8'h0d;

  localparam int          GFCFG_CMD_IO_BIT   = 0;
  localparam int          GFCFG_CMD_MEM_BIT  = 1;
  localparam int          GFCFG_CMD_BM_BIT   = 2;
  localparam int          GFCFG_CMD_SC_BIT   = 3;

  localparam logic [15:0] GFCFG_CMD_RST      = 16'h0004;
  localparam logic [15:0] GFCFG_STS_VAL      = 16'h02b0;
  localparam logic [7:0]  GFCFG_PROGIF_VAL   = 8'h00;
  localparam logic [7:0]  GFCFG_SUBCLASS_VAL = 8'h00;
  localparam logic [7:0]  GFCFG_BASECLS_VAL  = 8'h03;
  localparam logic [7:0]  GFCFG_LINESZ_VAL   = 8'h00;
  localparam logic [7:0]  GFCFG_LATTMR_VAL   = 8'h00;
  localparam logic [1:0]  GFCFG_DEVSEL_MED   = 2'h1;

  // Arbitrary neutral revision parts, not any real part's value
  localparam logic [3:0]  GFCFG_REV_PROCESS  = 4'h0;
  localparam logic [3:0]  GFCFG_REV_STEPPING = 4'h1;

  // Config access request: dword address, byte enables, write data
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  dw_addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } gfcfg_req_s;

  // Space access from the decoder
  typedef struct packed {
    logic mem_hit;
    logic io_hit;
  } gfcfg_space_s;

endpackage : gfcfg_pkg

// *** rtl/gfcfg_space.sv ***
// Memory and I/O space response gating
`timescale 1ns/10ps
module gfcfg_space (
  input  wire logic                memory_decode_enable,
  input  wire logic                io_decode_enable,
  input  wire logic                mem_req,
  input  wire logic                io_req,
  output gfcfg_pkg::gfcfg_space_s  space_hit
);
  import gfcfg_pkg::*;

  assign space_hit.mem_hit = mem_req & memory_decode_enable; // RULE_02
  assign space_hit.io_hit  = io_req & io_decode_enable;      // RULE_03
endmodule : gfcfg_space

// *** rtl/gfcfg_status.sv ***
// Hardwired status word assembly
`timescale 1ns/10ps
module gfcfg_status (
  output logic [15:0] status_word
);
  import gfcfg_pkg::*;

  logic       parity_error_seen;
  logic       system_error_signalled;
  logic       master_abort_received;
  logic       target_abort_received;
  logic       target_abort_signalled;
  logic [1:0] select_timing_field;
  logic       data_parity_flag;
  logic       back_to_back_capable;
  logic       user_format_flag;
  logic       high_speed_capable;
  logic       cap_list_present;

  assign parity_error_seen      = 1'b0; // RULE_04
  assign system_error_signalled = 1'b0; // RULE_05
  assign master_abort_received  = 1'b0; // RULE_06
  assign target_abort_received  = 1'b0; // RULE_07
  assign target_abort_signalled = 1'b0; // RULE_08
  assign select_timing_field    = GFCFG_DEVSEL_MED; // RULE_09
  assign data_parity_flag       = 1'b0; // RULE_10
  assign back_to_back_capable   = 1'b1; // RULE_11
  assign user_format_flag       = 1'b0; // RULE_12
  assign high_speed_capable     = 1'b1; // RULE_13
  assign cap_list_present       = 1'b1; // RULE_14

  assign status_word = {parity_error_seen, system_error_signalled, master_abort_received,
                        target_abort_received, target_abort_signalled, select_timing_field,
                        data_parity_flag, back_to_back_capable, user_format_flag,
                        high_speed_capable, cap_list_present, 4'h0};
endmodule : gfcfg_status

// *** rtl/gfcfg_top.sv ***
// Configuration header registers of the graphics function
`timescale 1ns/10ps

// Function
// (RULE_01) Bus master bit always reads one.
// (RULE_02) Memory decode enable writable, resets zero, gates memory space response.
// (RULE_03) I/O decode enable writable, resets zero, gates I/O space response.
// (RULE_04) Detected parity error status reads zero.
// (RULE_05) Signalled system error reads zero; error line never driven.
// (RULE_06) Received master abort status reads zero.
// (RULE_07) Received target abort status reads zero.
// (RULE_08) Signalled target abort reads zero; never target-aborts.
// (RULE_09) Select timing field fixed at 01, medium decode.
// (RULE_10) Data parity detected bit stays zero.
// (RULE_11) Fast back-to-back capable bit reads one.
// (RULE_12) User defined format bit reads zero.
// (RULE_13) High speed capable bit reads one.
// (RULE_14) Capability list bit reads one; status bits 3:0 reserved zero.
// (RULE_15) Revision byte: process upper nibble, stepping lower; writes ignored.
// (RULE_16) Programming interface byte reads 00h.
// (RULE_17) Sub-class byte reads 00h.
// (RULE_18) Base class byte reads 03h.
// (RULE_19) Cache line size byte reads zero.
// (RULE_20) Latency timer byte reads zero, ignores writes.
// (RULE_21) Special cycle response bit reads zero; special cycles ignored.
// (RULE_22) Writes to read-only bits complete without changing reads.
module gfcfg_top (
  input  wire logic                clock,
  input  wire logic                srst,
  input  gfcfg_pkg::gfcfg_req_s    cfg_req,
  output logic                     cfg_ack,
  output logic [31:0]              cfg_rdata,
  input  wire logic                mem_req,
  input  wire logic                io_req,
  output logic                     mem_claim,
  output logic                     io_claim,
  output logic                     serr_out,
  output logic                     serr_oe,
  output logic                     target_abort,
  output logic                     special_cycle_claim
);
  import gfcfg_pkg::*;

  logic         memory_decode_enable_r;
  logic         io_decode_enable_r;
  logic [15:0]  status_word;
  logic [15:0]  function_command;
  logic [7:0]   silicon_revision;
  logic [31:0]  rdata_nxt;
  logic [31:0]  cfg_rdata_r;
  logic         cfg_ack_r;
  gfcfg_space_s space_hit;

  function automatic logic hit_dword(input logic [5:0] dw, input logic [7:0] ofs);
    hit_dword = (dw == ofs[7:2]);
  endfunction : hit_dword

  // Only bits 1:0 of the command word store; others are constants
  always_comb begin
    function_command                     = GFCFG_CMD_RST;
    function_command[GFCFG_CMD_BM_BIT]   = 1'b1; // RULE_01
    function_command[GFCFG_CMD_SC_BIT]   = 1'b0; // RULE_21
    function_command[GFCFG_CMD_MEM_BIT]  = memory_decode_enable_r;
    function_command[GFCFG_CMD_IO_BIT]   = io_decode_enable_r;
  end

  assign silicon_revision = {GFCFG_REV_PROCESS, GFCFG_REV_STEPPING}; // RULE_15

  gfcfg_status u_status (
    .status_word (status_word)
  );

  gfcfg_space u_space (
    .memory_decode_enable (memory_decode_enable_r),
    .io_decode_enable     (io_decode_enable_r),
    .mem_req              (mem_req),
    .io_req               (io_req),
    .space_hit            (space_hit)
  );

  // Enables written through byte lane 0 of the command dword
  always_ff @(posedge clock) begin
    if (srst) begin
      memory_decode_enable_r <= 1'b0; // RULE_02
    end else if (cfg_req.wr && cfg_req.be[0] && hit_dword(cfg_req.dw_addr, GFCFG_OFS_CMD)) begin
      memory_decode_enable_r <= cfg_req.wdata[GFCFG_CMD_MEM_BIT]; // RULE_02
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      io_decode_enable_r <= 1'b0; // RULE_03
    end else if (cfg_req.wr && cfg_req.be[0] && hit_dword(cfg_req.dw_addr, GFCFG_OFS_CMD)) begin
      io_decode_enable_r <= cfg_req.wdata[GFCFG_CMD_IO_BIT]; // RULE_03
    end
  end

  // Read mux; all other dwords of the header read zero here
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_dword(cfg_req.dw_addr, GFCFG_OFS_CMD)) begin
      rdata_nxt = {status_word, function_command};
    end else if (hit_dword(cfg_req.dw_addr, GFCFG_OFS_REV)) begin
      rdata_nxt = {GFCFG_BASECLS_VAL, GFCFG_SUBCLASS_VAL, GFCFG_PROGIF_VAL,
                   silicon_revision}; // RULE_16 RULE_17 RULE_18
    end else if (hit_dword(cfg_req.dw_addr, GFCFG_OFS_LINESZ)) begin
      rdata_nxt = {16'h0000, GFCFG_LATTMR_VAL, GFCFG_LINESZ_VAL}; // RULE_19 RULE_20
    end
  end

  // Every access, read or write, acks one cycle later
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_ack_r <= 1'b0;
    end else begin
      cfg_ack_r <= cfg_req.rd | cfg_req.wr; // RULE_22
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_rdata_r <= 32'h0000_0000;
    end else if (cfg_req.rd) begin
      cfg_rdata_r <= rdata_nxt;
    end
  end

  assign cfg_ack             = cfg_ack_r;
  assign cfg_rdata           = cfg_rdata_r;
  assign mem_claim           = space_hit.mem_hit; // RULE_02
  assign io_claim            = space_hit.io_hit;  // RULE_03
  assign serr_out            = 1'b0; // RULE_05
  assign serr_oe             = 1'b0; // RULE_05
  assign target_abort        = 1'b0; // RULE_08
  assign special_cycle_claim = 1'b0; // RULE_21

  // Properties
  property p_mem_gate;
    @(posedge clock) disable iff (srst) mem_claim == (mem_req && memory_decode_enable_r);
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("memory claim not gated"); // RULE_02

  property p_io_gate;
    @(posedge clock) disable iff (srst) io_claim |-> io_decode_enable_r;
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("io claim while disabled"); // RULE_03

  property p_reset_clear;
    @(posedge clock) srst |=> (!memory_decode_enable_r && !io_decode_enable_r);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enables not cleared"); // RULE_02

  sequence s_cmd_read;
    cfg_req.rd && hit_dword(cfg_req.dw_addr, GFCFG_OFS_CMD);
  endsequence
  property p_cmd_read;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> (cfg_ack && cfg_rdata[2] && !cfg_rdata[3] && cfg_rdata[31:16] == 16'h02b0);
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("bad command/status read"); // RULE_01

  property p_status_const;
    @(posedge clock) status_word == GFCFG_STS_VAL;
  endproperty
  a_status_const: assert property (p_status_const) else $error("status not 02b0"); // RULE_09

  property p_class_read;
    @(posedge clock) disable iff (srst) cfg_req.rd && hit_dword(cfg_req.dw_addr, GFCFG_OFS_REV)
      |=> cfg_rdata[31:8] == 24'h030000;
  endproperty
  a_class_read: assert property (p_class_read) else $error("bad class bytes"); // RULE_18

  property p_lat_read;
    @(posedge clock) disable iff (srst) cfg_req.rd && hit_dword(cfg_req.dw_addr, GFCFG_OFS_LINESZ)
      |=> cfg_rdata[15:0] == 16'h0000;
  endproperty
  a_lat_read: assert property (p_lat_read) else $error("line/latency nonzero"); // RULE_20

  property p_write_ack;
    @(posedge clock) disable iff (srst) cfg_req.wr |=> cfg_ack;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("write not completed"); // RULE_22

  property p_no_serr;
    @(posedge clock) !serr_oe && !target_abort && !special_cycle_claim;
  endproperty
  a_no_serr: assert property (p_no_serr) else $error("forbidden output driven"); // RULE_05

  property p_mem_write;
    @(posedge clock) disable iff (srst)
      cfg_req.wr && cfg_req.be[0] && hit_dword(cfg_req.dw_addr, GFCFG_OFS_CMD)
      |=> memory_decode_enable_r == $past(cfg_req.wdata[1]);
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("enable write lost"); // RULE_02

  sequence s_cmd_write;
    cfg_req.wr && cfg_req.be[0] && hit_dword(cfg_req.dw_addr, GFCFG_OFS_CMD);
  endsequence

  sequence s_rev_read;
    cfg_req.rd && hit_dword(cfg_req.dw_addr, GFCFG_OFS_REV);
  endsequence

  sequence s_line_read;
    cfg_req.rd && hit_dword(cfg_req.dw_addr, GFCFG_OFS_LINESZ);
  endsequence

  sequence s_lone_access;
    (cfg_req.rd || cfg_req.wr) ##1 !(cfg_req.rd || cfg_req.wr);
  endsequence

  property p_bm_read;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> cfg_rdata[GFCFG_CMD_BM_BIT];
  endproperty
  a_bm_read: assert property (p_bm_read) else $error("master bit not one"); // RULE_01

  property p_mem_read;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> cfg_rdata[GFCFG_CMD_MEM_BIT] == $past(memory_decode_enable_r);
  endproperty
  a_mem_read: assert property (p_mem_read) else $error("mem enable misread"); // RULE_02

  property p_io_read;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> cfg_rdata[GFCFG_CMD_IO_BIT] == $past(io_decode_enable_r);
  endproperty
  a_io_read: assert property (p_io_read) else $error("io enable misread"); // RULE_03

  property p_io_write;
    @(posedge clock) disable iff (srst)
      s_cmd_write |=> io_decode_enable_r == $past(cfg_req.wdata[GFCFG_CMD_IO_BIT]);
  endproperty
  a_io_write: assert property (p_io_write) else $error("io write lost"); // RULE_03

  property p_mem_hold;
    @(posedge clock) disable iff (srst)
      !(cfg_req.wr && cfg_req.be[0] && hit_dword(cfg_req.dw_addr, GFCFG_OFS_CMD))
      |=> $stable(memory_decode_enable_r);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("mem enable drifted"); // RULE_02

  property p_io_hold;
    @(posedge clock) disable iff (srst)
      !(cfg_req.wr && cfg_req.be[0] && hit_dword(cfg_req.dw_addr, GFCFG_OFS_CMD))
      |=> $stable(io_decode_enable_r);
  endproperty
  a_io_hold: assert property (p_io_hold) else $error("io enable drifted"); // RULE_03

  property p_par_seen;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> !cfg_rdata[31];
  endproperty
  a_par_seen: assert property (p_par_seen) else $error("parity bit set"); // RULE_04

  property p_sys_err;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> !cfg_rdata[30] && !serr_out;
  endproperty
  a_sys_err: assert property (p_sys_err) else $error("system error set"); // RULE_05

  property p_mabort_rx;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> !cfg_rdata[29];
  endproperty
  a_mabort_rx: assert property (p_mabort_rx) else $error("master abort set"); // RULE_06

  property p_tabort_rx;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> !cfg_rdata[28];
  endproperty
  a_tabort_rx: assert property (p_tabort_rx) else $error("rx abort set"); // RULE_07

  property p_tabort_tx;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> !cfg_rdata[27] && !target_abort;
  endproperty
  a_tabort_tx: assert property (p_tabort_tx) else $error("tx abort set"); // RULE_08

  property p_sel_timing;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> cfg_rdata[26:25] == GFCFG_DEVSEL_MED;
  endproperty
  a_sel_timing: assert property (p_sel_timing) else $error("bad select timing"); // RULE_09

  property p_data_par;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> !cfg_rdata[24];
  endproperty
  a_data_par: assert property (p_data_par) else $error("data parity set"); // RULE_10

  property p_b2b;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> cfg_rdata[23];
  endproperty
  a_b2b: assert property (p_b2b) else $error("b2b bit clear"); // RULE_11

  property p_user_fmt;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> !cfg_rdata[22];
  endproperty
  a_user_fmt: assert property (p_user_fmt) else $error("user format set"); // RULE_12

  property p_high_speed;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> cfg_rdata[21];
  endproperty
  a_high_speed: assert property (p_high_speed) else $error("speed bit clear"); // RULE_13

  property p_cap_list;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> cfg_rdata[20] && cfg_rdata[19:16] == 4'h0;
  endproperty
  a_cap_list: assert property (p_cap_list) else $error("bad cap bits"); // RULE_14

  property p_rev_read;
    @(posedge clock) disable iff (srst)
      s_rev_read |=> cfg_rdata[7:0] == {GFCFG_REV_PROCESS, GFCFG_REV_STEPPING};
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("bad revision"); // RULE_15

  property p_progif_read;
    @(posedge clock) disable iff (srst)
      s_rev_read |=> cfg_rdata[15:8] == GFCFG_PROGIF_VAL;
  endproperty
  a_progif_read: assert property (p_progif_read) else $error("bad prog if"); // RULE_16

  property p_subclass_read;
    @(posedge clock) disable iff (srst)
      s_rev_read |=> cfg_rdata[23:16] == GFCFG_SUBCLASS_VAL;
  endproperty
  a_subclass_read: assert property (p_subclass_read) else $error("bad subclass"); // RULE_17

  property p_line_size;
    @(posedge clock) disable iff (srst)
      s_line_read |=> cfg_rdata[7:0] == GFCFG_LINESZ_VAL;
  endproperty
  a_line_size: assert property (p_line_size) else $error("line size nonzero"); // RULE_19

  property p_special_cycle;
    @(posedge clock) disable iff (srst)
      s_cmd_read |=> !cfg_rdata[GFCFG_CMD_SC_BIT] && !special_cycle_claim;
  endproperty
  a_special_cycle: assert property (p_special_cycle) else $error("special cycle on"); // RULE_21

  property p_ack_pulse;
    @(posedge clock) disable iff (srst)
      s_lone_access |-> cfg_ack ##1 !cfg_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a pulse"); // RULE_22

  property p_rdata_hold;
    @(posedge clock) disable iff (srst)
      !cfg_req.rd |=> $stable(cfg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // RULE_22

endmodule : gfcfg_top

// *** tb/gfcfg_host_model.sv ***
// Host bridge model issuing configuration reads and writes
`timescale 1ns/10ps
module gfcfg_host_model (
  input  wire logic           clock,
  output gfcfg_pkg::gfcfg_req_s cfg_req,
  input  wire logic           cfg_ack,
  input  wire logic [31:0]    cfg_rdata
);
  import gfcfg_pkg::*;

  initial cfg_req = '0;

  // Called at a falling edge; one request cycle, answer sampled a cycle later,
  // then one idle cycle so the next call never rewrites a line in the same step
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    cfg_req = '{rd: !wr, wr: wr, dw_addr: dw, be: be, wdata: wd};
    @(negedge clock);
    ok = (cfg_ack === 1'b1);
    rd = cfg_rdata;
    cfg_req.rd = 1'b0;
    cfg_req.wr = 1'b0;
    // Released lines flip so a late capture never sees the old value
    cfg_req.wdata = ~wd;
    cfg_req.dw_addr = ~dw;
    @(negedge clock);
    // Ack is a one-cycle pulse, gone once the idle cycle is taken
    ok = ok && (cfg_ack === 1'b0);
  endtask : access
endmodule : gfcfg_host_model

// *** tb/tb.sv ***
// Self-checking bench for the graphics config header
`timescale 1ns/10ps
module tb;
  import gfcfg_pkg::*;
  logic        clock, srst, mem_req, io_req, cfg_ack, mem_claim, io_claim;
  logic        serr_out, serr_oe, target_abort, special_cycle_claim;
  logic [31:0] cfg_rdata, rd;
  gfcfg_req_s  cfg_req;
  int          err_total, checks;
  // Expected class dword: base 03, sub 00, progif 00, arbitrary revision
  localparam logic [31:0] CLASS_REV = {24'h030000, GFCFG_REV_PROCESS, GFCFG_REV_STEPPING};

  gfcfg_top i_gfcfg_top (.clock(clock), .srst(srst), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .mem_req(mem_req), .io_req(io_req), .mem_claim(mem_claim),
    .io_claim(io_claim), .serr_out(serr_out), .serr_oe(serr_oe),
    .target_abort(target_abort), .special_cycle_claim(special_cycle_claim));
  gfcfg_host_model u_host (.clock(clock), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                      input logic [31:0] wd);
    logic ok;
    u_host.access(wr, dw, be, wd, rd, ok);
    chk({31'h0, ok}, 32'h1, "ack");
    chk({28'h0, serr_out, serr_oe, target_abort, special_cycle_claim}, 32'h0, "quiet");
  endtask : xfer

  // Claims are combinational, so look a little after the falling edge
  task automatic chk_claims(input logic m, input logic i, input logic em, input logic ei);
    mem_req = m;
    io_req = i;
    #1;
    chk({30'h0, mem_claim, io_claim}, {30'h0, em, ei}, "claims");
    @(negedge clock);
  endtask : chk_claims

  task automatic test_defaults;
    xfer(1'b0, 6'h01, 4'hf, 32'h0);
    chk(rd, 32'h02b0_0004, "cmd/status");
    xfer(1'b0, 6'h02, 4'hf, 32'h0);
    chk(rd, CLASS_REV, "class/rev");
    xfer(1'b0, 6'h03, 4'hf, 32'h0);
    chk(rd, 32'h0, "line/lat");
    xfer(1'b0, 6'h05, 4'hf, 32'h0);
    chk(rd, 32'h0, "unmapped");
    chk_claims(1'b1, 1'b1, 1'b0, 1'b0);
    $display("test defaults done");
  endtask : test_defaults

  task automatic test_ro_writes;
    xfer(1'b1, 6'h01, 4'hf, 32'hffff_ffff);
    xfer(1'b1, 6'h02, 4'hf, 32'hffff_ffff);
    xfer(1'b1, 6'h03, 4'hf, 32'hffff_ffff);
    xfer(1'b0, 6'h01, 4'hf, 32'h0);
    chk(rd, 32'h02b0_0007, "cmd/status");
    xfer(1'b0, 6'h02, 4'hf, 32'h0);
    chk(rd, CLASS_REV, "class/rev");
    xfer(1'b0, 6'h03, 4'hf, 32'h0);
    chk(rd, 32'h0, "line/lat");
    chk_claims(1'b1, 1'b1, 1'b1, 1'b1);
    chk_claims(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test read-only writes done");
  endtask : test_ro_writes

  task automatic test_enables;
    xfer(1'b1, 6'h01, 4'he, 32'h0);
    xfer(1'b0, 6'h01, 4'hf, 32'h0);
    chk(rd, 32'h02b0_0007, "lane gating");
    xfer(1'b1, 6'h01, 4'h1, 32'h2);
    xfer(1'b0, 6'h01, 4'hf, 32'h0);
    chk(rd, 32'h02b0_0006, "mem only");
    chk_claims(1'b1, 1'b1, 1'b1, 1'b0);
    xfer(1'b1, 6'h01, 4'h1, 32'h1);
    chk_claims(1'b1, 1'b1, 1'b0, 1'b1);
    $display("test enables done");
  endtask : test_enables

  task automatic test_reset_mid;
    xfer(1'b1, 6'h01, 4'h1, 32'h3);
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    xfer(1'b0, 6'h01, 4'hf, 32'h0);
    chk(rd, 32'h02b0_0004, "after reset");
    chk_claims(1'b1, 1'b1, 1'b0, 1'b0);
    $display("test mid-run reset done");
  endtask : test_reset_mid

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    srst = 1'b1;
    mem_req = 1'b0;
    io_req = 1'b0;
    repeat (20) @(negedge clock);
    srst = 1'b0;
    test_defaults();
    test_ro_writes();
    test_enables();
    test_reset_mid();
    complete_run();
  end

  // Whole run needs well under 100 cycles after reset
  initial begin
    #20000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule : tb
